// *** inc/nvm_pkg.sv ***
package nvm_pkg;
   // Control register bit positions.
   localparam int READ_BIT  = 0;
   localparam int WRITE_BIT = 1;
   localparam int ARM_BIT   = 2;
   localparam int IRQE_BIT  = 3;
   // Control register reset value.
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // Device register indexes on the CPU-side port.
   localparam logic [1:0] REG_CTRL  = 2'h0;
   localparam logic [1:0] REG_ADDRL = 2'h1;
   localparam logic [1:0] REG_ADDRH = 2'h2;
   localparam logic [1:0] REG_DATA  = 2'h3;
   // Avalon byte offsets of the controller registers.
   localparam logic [4:0] AV_CMD    = 5'h00;
   localparam logic [4:0] AV_ADDR   = 5'h04;
   localparam logic [4:0] AV_DATA   = 5'h08;
   localparam logic [4:0] AV_STATUS = 5'h0C;
   localparam logic [4:0] AV_IRQ_STATUS = 5'h10;
   localparam logic [4:0] AV_IRQ_CLEAR  = 5'h14;
   localparam logic [4:0] AV_IRQ_ENABLE = 5'h18;
   // Timing.
   localparam int ARM_CYCLES   = 4;
   localparam int WSTALL_CYC   = 2;
   localparam int RSTALL_CYC   = 4;
   localparam int OSC_CYCLES   = 8448;
   localparam int OSC_MHZ      = 1;
   localparam int CLK_MHZ      = 125;
   localparam int WRITE_CYCLES = OSC_CYCLES * CLK_MHZ / OSC_MHZ;
   localparam int ADDR_W       = 10;
endpackage

// *** inc/nvm_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface nvm_if;
   logic       regWrite;
   logic       regRead;
   logic [1:0] regIndex;
   logic [7:0] regWdata;
   logic [7:0] regRdata;
   logic       cpuStall;
   logic       readyIrq;
   logic       flashSelfProgramActive;
   modport device (input regWrite, regRead, regIndex, regWdata, flashSelfProgramActive,
                   output regRdata, cpuStall, readyIrq);
   modport host (output regWrite, regRead, regIndex, regWdata, flashSelfProgramActive,
                 input regRdata, cpuStall, readyIrq);
endinterface
`default_nettype wire

// *** verilog/nvm_access_device.sv ***
`timescale 1ns/1ps
`default_nettype none
// Function
// (R1) Armed write strobe starts programming.
// (R2) Unarmed write strobe does nothing.
// (R3) Arm bit self-clears after four cycles.
// (R4) Write strobe clears when programming ends.
// (R5) Write lasts 8448 one-megahertz oscillator cycles.
// (R6) Write start stalls CPU two cycles.
// (R7) Read strobe loads data immediately.
// (R8) Read stalls CPU four cycles.
// (R9) Writes block reads and address changes.
// (R10) No programming while flash programming.
// (R11) Software follows the ordered write sequence.
// (R12) Software disables interrupts during sequence; the host sequencer leaves irq unmasked.
// (R13) Software polls write strobe before reads.
// (R14) Write completes through power-down.
// (R15) Write completes through reset.
// (R16) Ready interrupt while enabled and idle.
// (R17) Ten-bit address, upper bits read zero.
// (R18) Data register holds write or read byte.
// (R19) Read strobe clears itself.
module nvm_access_device #(
   parameter int WRITE_CYCLES = nvm_pkg::WRITE_CYCLES
) (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic globalIrqEnable,
   nvm_if.device     bus
);
   logic [7:0]  mem [0:1023];
   logic [9:0]  address;
   logic [7:0]  dataByte;
   logic        irqEnable;
   logic        arm;
   logic [2:0]  armCount;
   logic        busy;
   logic [9:0]  progAddr;
   logic [7:0]  progData;
   logic [20:0] progCount; // The full write count at the system clock needs 21 bits.
   logic [2:0]  stallCount;
   logic        readPulse;

   // Decoded control-register effects.
   wire ctrlWr   = bus.regWrite && bus.regIndex == nvm_pkg::REG_CTRL;
   wire armSet   = ctrlWr && bus.regWdata[nvm_pkg::ARM_BIT] && !bus.regWdata[nvm_pkg::WRITE_BIT];
   wire startWr  = ctrlWr && bus.regWdata[nvm_pkg::WRITE_BIT] && arm && !busy
                   && !bus.flashSelfProgramActive; // R1 R2 R10
   wire startRd  = ctrlWr && bus.regWdata[nvm_pkg::READ_BIT] && !busy; // R9
   wire [7:0] ctrlView = {4'h0, irqEnable, arm, busy, readPulse};
   wire [7:0] rdMux = (bus.regIndex == nvm_pkg::REG_CTRL)  ? ctrlView :
                      (bus.regIndex == nvm_pkg::REG_ADDRL) ? address[7:0] :
                      (bus.regIndex == nvm_pkg::REG_ADDRH) ? {6'h00, address[9:8]} : dataByte; // R17

   assign bus.readyIrq = irqEnable && globalIrqEnable && !busy; // R16
   assign bus.cpuStall = stallCount != 3'h0;
   assign bus.regRdata = rdMux;

   // Programming engine; reset does not abort a write in flight, so the array outlives reset.
   always_ff @(posedge ref_clk) begin
      if (startWr) begin
         busy      <= 1'b1;
         progAddr  <= address;
         progData  <= dataByte;
         progCount <= 21'(WRITE_CYCLES - 1); // R5
      end else if (busy) begin
         if (progCount == 21'h00_0000) begin
            busy          <= 1'b0; // R4
            mem[progAddr] <= progData; // R14 R15
         end else begin
            progCount <= progCount - 21'h00_0001;
         end
      end else if (rst) begin
         busy <= 1'b0;
      end
   end

   // Register file, arm window and stall counter.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irqEnable  <= 1'b0;
         arm        <= 1'b0;
         armCount   <= 3'h0;
         stallCount <= 3'h0;
         readPulse  <= 1'b0;
         address    <= 10'h000;
         dataByte   <= 8'h00;
      end else begin
         readPulse <= startRd; // R19
         if (armSet) begin
            arm      <= 1'b1;
            armCount <= 3'(nvm_pkg::ARM_CYCLES);
         end else if (armCount != 3'h0) begin
            armCount <= armCount - 3'h1;
            if (armCount == 3'h1 || startWr) arm <= 1'b0; // R3
         end
         if (startWr) stallCount <= 3'(nvm_pkg::WSTALL_CYC); // R6
         else if (startRd) stallCount <= 3'(nvm_pkg::RSTALL_CYC); // R8
         else if (stallCount != 3'h0) stallCount <= stallCount - 3'h1;
         if (startRd) dataByte <= mem[address]; // R7 R18
         else if (bus.regWrite && bus.regIndex == nvm_pkg::REG_DATA) dataByte <= bus.regWdata; // R18
         if (ctrlWr) irqEnable <= bus.regWdata[nvm_pkg::IRQE_BIT];
         if (bus.regWrite && !busy && bus.regIndex == nvm_pkg::REG_ADDRL) address[7:0] <= bus.regWdata; // R9
         if (bus.regWrite && !busy && bus.regIndex == nvm_pkg::REG_ADDRH) address[9:8] <= bus.regWdata[1:0];
      end
   end
endmodule // nvm_access_device
`default_nettype wire

// *** verilog/nvm_access_host.sv ***
// The implementer's own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
// Software-side sequencer: Avalon commands become the documented register sequences.
module nvm_access_host (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic [4:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   output logic             irq,
   input  wire logic        flashBusyPin,
   nvm_if.host              dev
);
   typedef enum logic [6:0] {
      IDLE = 7'b000_0001, POLL = 7'b000_0010, ADRL = 7'b000_0100, ADRH = 7'b000_1000,
      DATA = 7'b001_0000, ARM  = 7'b010_0000, STRB = 7'b100_0000
   } state_type;
   state_type   state;
   logic [9:0]  cmdAddr;
   logic [7:0]  cmdData;
   logic        isWrite;
   logic [7:0]  result;
   logic        done;
   logic [1:0]  irqStatus;
   logic [1:0]  irqEnable;
   logic        readValid;
   logic        flashMeta;
   logic        flashSync;

   // Avalon decode; commands wait while the sequencer is busy, and every read waits one cycle
   // so that the registered read data already stands when waitrequest drops.
   wire cmdHit  = write && address == nvm_pkg::AV_CMD;
   wire seqBusy = state != IDLE;
   wire devBusy = dev.regIndex == nvm_pkg::REG_CTRL && dev.regRdata[nvm_pkg::WRITE_BIT];
   wire [1:0] irqEvent = {done, dev.readyIrq};
   assign waitrequest = (cmdHit && seqBusy) || (read && !readValid);
   assign irq = |(irqStatus & irqEnable);
   assign dev.flashSelfProgramActive = flashSync; // R10

   // Pin synchroniser for the flash-programming flag.
   always_ff @(posedge ref_clk) begin
      flashMeta <= flashBusyPin;
      flashSync <= flashMeta;
   end

   // Register-port sequence; interrupts are not masked during it, and ARM copies irqEnable[0] into the device enable (R12).
   always_comb begin
      dev.regWrite = 1'b0;
      dev.regRead  = 1'b1;
      dev.regIndex = nvm_pkg::REG_CTRL;
      dev.regWdata = 8'h00;
      case (state)
         ADRL: begin dev.regWrite = 1'b1; dev.regIndex = nvm_pkg::REG_ADDRL; dev.regWdata = cmdAddr[7:0]; end
         ADRH: begin dev.regWrite = 1'b1; dev.regIndex = nvm_pkg::REG_ADDRH; dev.regWdata = {6'h00, cmdAddr[9:8]}; end
         DATA: begin dev.regWrite = 1'b1; dev.regIndex = nvm_pkg::REG_DATA; dev.regWdata = cmdData; end
         ARM:  begin dev.regWrite = 1'b1; dev.regWdata = {4'h0, irqEnable[0], 3'h4}; end // R11
         STRB: begin
            dev.regWrite = !dev.cpuStall;
            dev.regWdata = {4'h0, irqEnable[0], isWrite, isWrite, !isWrite}; // R11
            if (!isWrite) dev.regIndex = nvm_pkg::REG_CTRL;
         end
         IDLE: if (done && !isWrite) dev.regIndex = nvm_pkg::REG_DATA; // R7 R18
         default: ;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state <= IDLE; cmdAddr <= 10'h000; cmdData <= 8'h00; isWrite <= 1'b0;
         result <= 8'h00; done <= 1'b0; irqStatus <= 2'h0; irqEnable <= 2'h0; readdata <= 32'h0000_0000;
         readValid <= 1'b0;
      end else begin
         done <= 1'b0;
         irqStatus <= (irqStatus & ~((write && address == nvm_pkg::AV_IRQ_CLEAR) ? writedata[1:0] : 2'h0))
                      | irqEvent;
         if (write && address == nvm_pkg::AV_IRQ_ENABLE) irqEnable <= writedata[1:0];
         if (write && address == nvm_pkg::AV_ADDR) cmdAddr <= writedata[9:0];
         if (write && address == nvm_pkg::AV_DATA) cmdData <= writedata[7:0];
         readValid <= read && !readValid;
         if (read && !readValid) begin
            if (address == nvm_pkg::AV_ADDR) readdata <= {22'h00_0000, cmdAddr};
            else if (address == nvm_pkg::AV_DATA) readdata <= {24'h00_0000, result};
            else if (address == nvm_pkg::AV_STATUS) readdata <= {31'h0000_0000, seqBusy || devBusy}; // R4 R13
            else if (address == nvm_pkg::AV_IRQ_STATUS) readdata <= {30'h0000_0000, irqStatus};
            else if (address == nvm_pkg::AV_IRQ_ENABLE) readdata <= {30'h0000_0000, irqEnable};
            else readdata <= 32'h0000_0000;
         end
         case (state)
            IDLE: if (cmdHit) begin isWrite <= writedata[0]; state <= POLL; end
            POLL: if (!dev.regRdata[nvm_pkg::WRITE_BIT] && !flashSync && !dev.cpuStall) state <= ADRL; // R11 R13
            ADRL: state <= ADRH;
            ADRH: state <= isWrite ? DATA : STRB;
            DATA: state <= ARM;
            ARM:  state <= STRB;
            STRB: if (!dev.cpuStall) begin state <= IDLE; done <= 1'b1; end
            default: state <= IDLE;
         endcase
         if (state == IDLE && done && !isWrite) result <= dev.regRdata; // R7 R18
      end
   end
endmodule // nvm_access_host
`default_nettype wire

// *** verification/nvm_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
// Watches the register port between the two ends; helper counters mirror the arm window and write timer.
module nvm_asserts #(parameter int WRITE_CYCLES = 50) (
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic       globalIrqEnable,
   input wire logic       regWrite,
   input wire logic       regRead,
   input wire logic [1:0] regIndex,
   input wire logic [7:0] regWdata,
   input wire logic [7:0] regRdata,
   input wire logic       cpuStall,
   input wire logic       readyIrq,
   input wire logic       flashSelfProgramActive
);
   logic [3:0] armAge;
   int         busy;
   logic       irqOn;
   wire        ctrlWr = regWrite && regIndex == nvm_pkg::REG_CTRL;
   wire        startW = ctrlWr && regWdata[nvm_pkg::WRITE_BIT] && armAge < 4'h4 && busy == 0
                        && !flashSelfProgramActive;
   // The timer ignores reset on purpose, because a started write must run to its end.
   always_ff @(posedge ref_clk) begin
      busy   <= startW ? WRITE_CYCLES : (busy > 0 ? busy - 1 : 0);
      armAge <= (rst || startW) ? 4'hF
                : (ctrlWr && regWdata[nvm_pkg::ARM_BIT] && !regWdata[nvm_pkg::WRITE_BIT]) ? 4'h0
                : armAge + {3'h0, armAge != 4'hF};
      irqOn  <= rst ? 1'b0 : (ctrlWr ? regWdata[nvm_pkg::IRQE_BIT] : irqOn);
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence idleOn;
      busy == 0 && irqOn && globalIrqEnable;
   endsequence
   // Stall shapes: exactly two cycles after a write start, four after a read strobe.
   sequence writeStall;
      cpuStall [*2] ##1 !cpuStall;
   endsequence
   sequence readStall;
      cpuStall [*4] ##1 !cpuStall;
   endsequence
   write_stall_a: assert property (startW |=> writeStall) else $error("wrong stall on write");
   read_stall_a: assert property (ctrlWr && regWdata[0] && busy == 0 |=> readStall)
      else $error("wrong stall on read");
   stall_end_a: assert property ($rose(cpuStall) |-> ##[1:6] !cpuStall) else $error("stall too long");
   stall_cause_a: assert property ($rose(cpuStall) |-> ctrlWr || $past(ctrlWr) || $past(ctrlWr, 2))
      else $error("stall without strobe");
   busy_quiet_a: assert property (busy > 3 && busy < WRITE_CYCLES - 3 |-> !readyIrq)
      else $error("ready during write");
   done_ready_a: assert property (busy == 1 |-> ##[1:8] (readyIrq || !irqOn || !globalIrqEnable))
      else $error("write did not end");
   idle_ready_a: assert property (idleOn [*8] |-> readyIrq) else $error("ready missing");
   gie_gate_a: assert property (!globalIrqEnable [*2] |-> !readyIrq) else $error("ready ungated");
   addr_high_a: assert property (regRead && regIndex == nvm_pkg::REG_ADDRH |-> regRdata[7:2] == 6'h00)
      else $error("address high bits set");
   busy_flag_a: assert property (regIndex == nvm_pkg::REG_CTRL |-> regRdata[nvm_pkg::WRITE_BIT] == (busy > 0))
      else $error("write strobe differs from the armed write model");
   arm_window_a: assert property (regIndex == nvm_pkg::REG_CTRL |-> regRdata[nvm_pkg::ARM_BIT] == (armAge < 4'h4))
      else $error("arm bit differs from the four cycle window");
endmodule // nvm_asserts
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
// Drives the host over Avalon while the device answers across the shared interface.
module testbench;
   logic        ref_clk, rst, gie, read, write, pin, waitrequest, irq;
   logic [4:0]  address;
   logic [31:0] writedata, readdata, rd;
   int          miscompares, n_compared, n;
   nvm_if bus();
   nvm_access_device #(.WRITE_CYCLES(50)) nvm_access_device_inst (.ref_clk(ref_clk), .rst(rst),
      .globalIrqEnable(gie), .bus(bus));
   nvm_access_host nvm_access_host_inst (.ref_clk(ref_clk), .rst(rst), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
      .flashBusyPin(pin), .dev(bus));
   nvm_asserts #(.WRITE_CYCLES(50)) nvm_asserts_inst (.ref_clk(ref_clk), .rst(rst), .globalIrqEnable(gie),
      .regWrite(bus.regWrite), .regRead(bus.regRead), .regIndex(bus.regIndex), .regWdata(bus.regWdata),
      .regRdata(bus.regRdata), .cpuStall(bus.cpuStall), .readyIrq(bus.readyIrq),
      .flashSelfProgramActive(bus.flashSelfProgramActive));
   // Free-running clock.
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   task automatic report_and_stop();
      $display("compared %0d, mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask
   // One Avalon transfer, started just after a rising edge; the request stands until waitrequest is
   // seen low at a rising edge, read data is taken at that edge, and one idle edge follows.
   task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
      int k;
      k = 0;
      address   <= a;
      writedata <= d;
      write     <= w;
      read      <= !w;
      @(posedge ref_clk);
      while (waitrequest !== 1'b0 && k < 300) begin
         @(posedge ref_clk);
         k++;
      end
      if (k >= 300) begin
         miscompares++;
         report_and_stop();
      end
      rd = readdata;
      write <= 1'b0;
      read  <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic poll();
      n = 0;
      do begin
         av(1'b0, 5'h0C, 0);
         n++;
      end while (rd[0] !== 1'b0 && n < 200);
      if (n >= 200) begin
         miscompares++;
         report_and_stop();
      end
   endtask
   task automatic go(input logic [31:0] a, input logic [31:0] d, input logic [31:0] c);
      av(1'b1, 5'h04, a);
      av(1'b1, 5'h08, d);
      av(1'b1, 5'h00, c);
   endtask
   task automatic t_regs();
      av(1'b0, 5'h18, 0);
      chk("irq enable at reset", 0, rd);
      av(1'b1, 5'h1C, 32'hFFFF_FFFF);
      av(1'b0, 5'h18, 0);
      chk("irq enable after unmapped write", 0, rd);
      $display("register test done");
   endtask
   task automatic t_write();
      av(1'b1, 5'h18, 32'h0000_0003);
      @(posedge ref_clk) gie <= 1'b1;
      go(32'h0000_03FF, 32'h0000_00A5, 32'h0000_0001);
      poll();
      chk("write lasted", 1, 32'(n > 8));
      av(1'b0, 5'h10, 0);
      chk("done flag", 1, 32'(rd[1]));
      chk("ready flag", 1, 32'(rd[0]));
      chk("ready level", 1, 32'(bus.readyIrq));
      chk("irq", 1, 32'(irq));
      av(1'b1, 5'h14, 32'h0000_0002);
      av(1'b0, 5'h10, 0);
      chk("done cleared", 0, 32'(rd[1]));
      av(1'b1, 5'h18, 0);
      chk("irq masked", 0, 32'(irq));
      $display("write test done");
   endtask
   // Writing sixteen ones to the address also proves that only ten of them are kept.
   task automatic t_read();
      av(1'b1, 5'h04, 32'h0000_FFFF);
      av(1'b0, 5'h04, 0);
      chk("address width", 32'h0000_03FF, rd);
      av(1'b1, 5'h00, 0);
      poll();
      av(1'b0, 5'h08, 0);
      chk("read byte", 32'h0000_00A5, rd);
      $display("read test done");
   endtask
   task automatic t_reset();
      go(32'h0000_0010, 32'h0000_003C, 32'h0000_0001);
      // Let the sequencer reach the strobe so that the reset lands inside the programming time.
      repeat (8) @(posedge ref_clk);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      av(1'b0, 5'h0C, 0);
      chk("busy through reset", 1, 32'(rd[0]));
      poll();
      av(1'b1, 5'h04, 32'h0000_0010);
      av(1'b1, 5'h00, 0);
      poll();
      av(1'b0, 5'h08, 0);
      chk("byte after reset", 32'h0000_003C, rd);
      $display("reset test done");
   endtask
   task automatic t_flash();
      @(posedge ref_clk) pin <= 1'b1;
      go(32'h0000_0020, 32'h0000_0077, 32'h0000_0001);
      repeat (30) @(posedge ref_clk);
      av(1'b0, 5'h0C, 0);
      chk("held by flash", 1, 32'(rd[0]));
      @(posedge ref_clk) pin <= 1'b0;
      poll();
      av(1'b1, 5'h04, 32'h0000_0020);
      av(1'b1, 5'h00, 0);
      poll();
      av(1'b0, 5'h08, 0);
      chk("byte after flash", 32'h0000_0077, rd);
      $display("flash test done");
   endtask
   // Main sequence.
   initial begin
      rst = 1'b1;
      gie = 1'b0;
      read = 1'b0;
      write = 1'b0;
      pin = 1'b0;
      address = 5'h00;
      writedata = 32'h0000_0000;
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      t_regs();
      t_write();
      t_read();
      t_reset();
      t_flash();
      report_and_stop();
   end
endmodule // testbench
`default_nettype wire
